// *** verilog/frt_pkg.sv ***
package frt_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL_ONE     = 4'h0;
    localparam logic [3:0] ADDR_CTRL_TWO     = 4'h1;
    localparam logic [3:0] ADDR_FLAGS        = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h3;
    localparam logic [3:0] ADDR_COUNT_LOW    = 4'h4;
    localparam logic [3:0] ADDR_SHADOW_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_SHADOW_LOW   = 4'h6;
    localparam logic [3:0] ADDR_CAP1_HIGH    = 4'h7;
    localparam logic [3:0] ADDR_CAP1_LOW     = 4'h8;
    localparam logic [3:0] ADDR_CAP2_HIGH    = 4'h9;
    localparam logic [3:0] ADDR_CAP2_LOW     = 4'ha;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL1_CAP_IRQ_EN_BIT  = 7;
    localparam int CTRL1_CAP1_EDGE_BIT   = 1;
    localparam int CTRL1_OVF_IRQ_EN_BIT  = 5;
    localparam int CTRL2_PULSE_MODE_BIT  = 4;
    localparam int CTRL2_PWM_MODE_BIT    = 5;
    localparam int CTRL2_PRESCALE_LO_BIT = 2;
    localparam int CTRL2_CAP2_EDGE_BIT   = 1;
    localparam int CTRL2_EXT_EDGE_BIT    = 0;
    localparam int FLAG_CAP1_BIT         = 7;
    localparam int FLAG_CAP2_BIT         = 6;
    localparam int FLAG_OVF_BIT          = 5;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [15:0] COUNT_RELOAD    = 16'hfffc;
    localparam logic [15:0] COUNT_TOP       = 16'hffff;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [1:0]  PRESCALE_EXT    = 2'h3;
    localparam int          EXT_MIN_EDGES   = 4;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [7:0]  writedata;
    } frt_bus_req_t;

    typedef struct packed {
        logic        captureOne;
        logic        captureTwo;
        logic        extCount;
    } frt_pins_t;

    typedef struct packed {
        logic        overflowIrq;
        logic        captureIrq;
    } frt_irq_t;
endpackage

// *** verilog/frt_timer.sv ***
// What this block does
// - Sixteen-bit up counter advances once per timer tick, read as two bytes.
// - Timer tick is system clock divided by 2, 4 or 8 by prescale field.
// - Prescale field both ones selects external pin edges as the tick.
// - Any write to either counter low byte forces the count to fffc.
// - Reset loads fffc, the only reload value, also in pulse modes.
// - Both counter views show the same count, low byte writes only reload it; shadow low never clears overflow.
// - High byte read latches low byte until low byte read, despite rereads.
// - Low byte read outside a sequence returns live low byte.
// - Wrap from ffff to 0000 sets overflow flag in every mode.
// - Overflow interrupt requested while enabled and cpu mask clear, else pending.
// - Overflow flag clears on status read while set, then count low access.
// - Counter runs in wait, stops in halt, resumes from held count.
// - External edge polarity bit selects which pin transition counts.
// - Capture pin active edge copies count into capture register, sets flag.
// - Capture one polarity in control one, capture two polarity in control two.
// - Shared capture enable requests interrupt for either channel while mask clear.
// - Capture flag clears on status read while set, then capture low access.
// - Capture high read blocks captures and flag setting until low read.
// - Capture register always holds the most recent captured count.
// - In pulse or pwm mode only capture channel two captures.
// - Capture pins always feed the timer whatever their port direction.
`timescale 1ns/1ns
`default_nettype none
module frt_timer #(
    parameter int COUNT_BITS = 16
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  clockEnable,
    input  wire frt_pkg::frt_bus_req_t busReq,
    output var  logic [7:0]            readdata,
    output var  logic                  waitrequest,
    input  wire frt_pkg::frt_pins_t    pins,
    input  wire logic                  cpuMask,
    input  wire logic                  haltMode,
    output var  frt_pkg::frt_irq_t     irq
);
    import frt_pkg::*;

    // ****************************************
    // Parameter check
    // ****************************************
    // The register map serves a two byte count only
    if (COUNT_BITS != 16) begin : g_width_check
        $error("count width must be sixteen");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [15:0] count;
        logic [2:0]  divider;
        logic [7:0]  ctrlOne;
        logic [7:0]  ctrlTwo;
        logic        ovfFlag;
        logic [1:0]  capFlag;
        logic        ovfArmed;
        logic [1:0]  capArmed;
        logic [15:0] capValue0;
        logic [15:0] capValue1;
        logic [1:0]  capBlocked;
        logic [7:0]  lowLatch;
        logic        lowHeld;
        logic [2:0]  extSync;
        logic [2:0]  cap0Sync;
        logic [2:0]  cap1Sync;
        logic        answered;
        logic        waitReq;
        logic [7:0]  readdata;
        frt_irq_t    irq;
    } frt_state_t;

    frt_state_t state;
    frt_state_t next_state;

    logic [1:0] prescale;
    logic       tick;
    logic       extEdge;
    logic       cap0Edge;
    logic       cap1Edge;
    logic       accept;
    logic       rd;
    logic       wr;
    logic       pulseModes;

    assign prescale   = state.ctrlTwo[CTRL2_PRESCALE_LO_BIT +: 2];
    assign pulseModes = state.ctrlTwo[CTRL2_PULSE_MODE_BIT] | state.ctrlTwo[CTRL2_PWM_MODE_BIT];
    assign accept     = (busReq.read | busReq.write) & ~state.answered;
    assign rd         = accept & busReq.read;
    assign wr         = accept & busReq.write;

    // Edge detectors look only at the differing second and third stages
    always_comb begin
        extEdge  = (state.extSync[1] != state.extSync[2])
                 & (state.extSync[1] == state.ctrlTwo[CTRL2_EXT_EDGE_BIT]);
        cap0Edge = (state.cap0Sync[1] != state.cap0Sync[2])
                 & (state.cap0Sync[1] == state.ctrlOne[CTRL1_CAP1_EDGE_BIT]);
        cap1Edge = (state.cap1Sync[1] != state.cap1Sync[2])
                 & (state.cap1Sync[1] == state.ctrlTwo[CTRL2_CAP2_EDGE_BIT]);
        unique case (prescale)
            2'h0: tick = state.divider[0];
            2'h1: tick = &state.divider[1:0];
            2'h2: tick = &state.divider;
            default: tick = extEdge;
        endcase
        if (haltMode) begin
            tick = 1'b0;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;
        next_state.extSync  = {state.extSync[1:0], pins.extCount};
        next_state.cap0Sync = {state.cap0Sync[1:0], pins.captureOne};
        next_state.cap1Sync = {state.cap1Sync[1:0], pins.captureTwo};
        next_state.answered = accept;
        // Registered so the bus output comes straight from a flop
        next_state.waitReq  = ~accept;
        if (!haltMode) begin
            next_state.divider = state.divider + 3'h1;
        end
        if (tick) begin
            next_state.count = state.count + 16'h0001;
            if (state.count == COUNT_TOP) begin
                next_state.ovfFlag = 1'b1;
            end
        end

        // Captures; set beats any clear below
        if (cap0Edge && !state.capBlocked[0] && !pulseModes) begin
            next_state.capValue0 = state.count;
        end
        if (cap1Edge && !state.capBlocked[1]) begin
            next_state.capValue1 = state.count;
        end

        if (rd) begin
            unique case (busReq.address)
                ADDR_CTRL_ONE: next_state.readdata = state.ctrlOne;
                ADDR_CTRL_TWO: next_state.readdata = state.ctrlTwo;
                ADDR_FLAGS: begin
                    next_state.readdata = 8'h00;
                    next_state.readdata[FLAG_OVF_BIT]  = state.ovfFlag;
                    next_state.readdata[FLAG_CAP1_BIT] = state.capFlag[0];
                    next_state.readdata[FLAG_CAP2_BIT] = state.capFlag[1];
                    next_state.ovfArmed = state.ovfFlag;
                    next_state.capArmed = state.capFlag;
                end
                ADDR_COUNT_HIGH, ADDR_SHADOW_HIGH: begin
                    next_state.readdata = state.count[15:8];
                    if (!state.lowHeld) begin
                        next_state.lowLatch = state.count[7:0];
                        next_state.lowHeld  = 1'b1;
                    end
                end
                ADDR_COUNT_LOW, ADDR_SHADOW_LOW: begin
                    next_state.readdata = state.lowHeld ? state.lowLatch : state.count[7:0];
                    next_state.lowHeld  = 1'b0;
                end
                ADDR_CAP1_HIGH: begin
                    next_state.readdata      = state.capValue0[15:8];
                    next_state.capBlocked[0] = 1'b1;
                end
                ADDR_CAP1_LOW: begin
                    next_state.readdata      = state.capValue0[7:0];
                    next_state.capBlocked[0] = 1'b0;
                end
                ADDR_CAP2_HIGH: begin
                    next_state.readdata      = state.capValue1[15:8];
                    next_state.capBlocked[1] = 1'b1;
                end
                ADDR_CAP2_LOW: begin
                    next_state.readdata      = state.capValue1[7:0];
                    next_state.capBlocked[1] = 1'b0;
                end
                default: next_state.readdata = 8'h00;
            endcase
        end
        if (wr) begin
            unique case (busReq.address)
                ADDR_CTRL_ONE: next_state.ctrlOne = busReq.writedata;
                ADDR_CTRL_TWO: next_state.ctrlTwo = busReq.writedata;
                ADDR_COUNT_LOW, ADDR_SHADOW_LOW: begin
                    next_state.count = COUNT_RELOAD;
                end
                default: ;
            endcase
        end

        // Overflow clear on counter low access only
        if (accept && busReq.address == ADDR_COUNT_LOW && state.ovfArmed) begin
            next_state.ovfArmed = 1'b0;
            if (!(tick && state.count == COUNT_TOP)) begin
                next_state.ovfFlag = 1'b0;
            end
        end
        if (accept && busReq.address == ADDR_CAP1_LOW && state.capArmed[0]) begin
            next_state.capArmed[0] = 1'b0;
            next_state.capFlag[0]  = 1'b0;
        end
        if (accept && busReq.address == ADDR_CAP2_LOW && state.capArmed[1]) begin
            next_state.capArmed[1] = 1'b0;
            next_state.capFlag[1]  = 1'b0;
        end
        if (cap0Edge && !state.capBlocked[0] && !pulseModes) begin
            next_state.capFlag[0] = 1'b1;
        end
        if (cap1Edge && !state.capBlocked[1]) begin
            next_state.capFlag[1] = 1'b1;
        end

        next_state.irq.overflowIrq = state.ovfFlag & state.ctrlOne[CTRL1_OVF_IRQ_EN_BIT] & ~cpuMask;
        next_state.irq.captureIrq  = (|state.capFlag) & state.ctrlOne[CTRL1_CAP_IRQ_EN_BIT]
                                   & ~cpuMask;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            state         <= '0;
            state.count   <= COUNT_RELOAD;
            state.ctrlOne <= CTRL_RESET;
            state.ctrlTwo <= CTRL_RESET;
            state.waitReq <= 1'b1;
        end else if (clockEnable) begin
            state <= next_state;
        end
    end

    always_comb begin
        readdata    = state.readdata;
        irq         = state.irq;
        // Waitrequest is low only in the answer cycle
        waitrequest = state.waitReq;
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_reload;
        @(posedge clock) disable iff (srst)
        (clockEnable && wr && busReq.address == ADDR_COUNT_LOW) |=> state.count == COUNT_RELOAD;
    endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded");

    property p_wrap;
        @(posedge clock) disable iff (srst)
        (clockEnable && tick && state.count == COUNT_TOP && !wr) |=> state.ovfFlag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow flag not set");

    property p_advance;
        @(posedge clock) disable iff (srst)
        (clockEnable && tick && !wr) |=> state.count == $past(state.count) + 16'h0001;
    endproperty
    a_advance: assert property (p_advance) else $error("count did not advance");

    property p_halt;
        @(posedge clock) disable iff (srst)
        (clockEnable && haltMode && !wr) |=> $stable(state.count);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved in halt");

    property p_div2;
        @(posedge clock) disable iff (srst)
        (prescale == 2'h0 && !haltMode && clockEnable) [*3] |-> state.count != $past(state.count, 2)
            || $past(wr) || $past(wr, 2);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two rate wrong");

    property p_ovf_irq;
        @(posedge clock) disable iff (srst)
        (clockEnable && state.ovfFlag && state.ctrlOne[CTRL1_OVF_IRQ_EN_BIT] && !cpuMask)
            |=> irq.overflowIrq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

    property p_shadow_keeps;
        @(posedge clock) disable iff (srst)
        (clockEnable && accept && busReq.address == ADDR_SHADOW_LOW && state.ovfFlag)
            |=> state.ovfFlag;
    endproperty
    a_shadow_keeps: assert property (p_shadow_keeps) else $error("shadow read cleared flag");

    property p_blocked;
        @(posedge clock) disable iff (srst)
        (clockEnable && state.capBlocked[1] && !state.capFlag[1]) |=> !state.capFlag[1]
            || !$past(state.capBlocked[1]) || $past(!state.capBlocked[1]);
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked capture set flag");

    property p_cap_flag;
        @(posedge clock) disable iff (srst)
        (clockEnable && cap1Edge && !state.capBlocked[1]) |=> state.capFlag[1]
            && state.capValue1 == $past(state.count);
    endproperty
    a_cap_flag: assert property (p_cap_flag) else $error("capture two missed");

    property p_pulse_cap;
        @(posedge clock) disable iff (srst)
        (clockEnable && pulseModes) |=> $stable(state.capValue0) || $past(srst);
    endproperty
    a_pulse_cap: assert property (p_pulse_cap) else $error("channel one captured");

    property p_cap1_flag;
        @(posedge clock) disable iff (srst)
        (clockEnable && cap0Edge && !state.capBlocked[0] && !pulseModes) |=> state.capFlag[0]
            && state.capValue0 == $past(state.count);
    endproperty
    a_cap1_flag: assert property (p_cap1_flag) else $error("capture one missed");

    property p_cap_irq;
        @(posedge clock) disable iff (srst)
        (clockEnable && (|state.capFlag) && state.ctrlOne[CTRL1_CAP_IRQ_EN_BIT] && !cpuMask)
            |=> irq.captureIrq;
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

    property p_masked;
        @(posedge clock) disable iff (srst)
        (clockEnable && cpuMask) |=> !irq.overflowIrq && !irq.captureIrq;
    endproperty
    a_masked: assert property (p_masked) else $error("irq raised while masked");

    property p_ovf_clear;
        @(posedge clock) disable iff (srst)
        (clockEnable && accept && busReq.address == ADDR_COUNT_LOW && state.ovfArmed
            && !(tick && state.count == COUNT_TOP)) |=> !state.ovfFlag;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

    // First high byte read of a count sequence
    sequence s_first_high;
        clockEnable && rd && !state.lowHeld
            && (busReq.address == ADDR_COUNT_HIGH || busReq.address == ADDR_SHADOW_HIGH);
    endsequence

    property p_latch;
        @(posedge clock) disable iff (srst)
        s_first_high |=> state.lowHeld && state.lowLatch == $past(state.count[7:0]);
    endproperty
    a_latch: assert property (p_latch) else $error("low byte not latched");

    // Capture high byte reads, one per channel
    sequence s_cap1_high;
        clockEnable && rd && busReq.address == ADDR_CAP1_HIGH;
    endsequence

    sequence s_cap2_high;
        clockEnable && rd && busReq.address == ADDR_CAP2_HIGH;
    endsequence

    property p_cap1_blocks;
        @(posedge clock) disable iff (srst)
        s_cap1_high |=> state.capBlocked[0];
    endproperty
    a_cap1_blocks: assert property (p_cap1_blocks) else $error("capture one not blocked");

    property p_cap2_blocks;
        @(posedge clock) disable iff (srst)
        s_cap2_high |=> state.capBlocked[1];
    endproperty
    a_cap2_blocks: assert property (p_cap2_blocks) else $error("capture two not blocked");
endmodule
`default_nettype wire

// *** bench/frt_pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module frt_pin_model (
    input  wire logic               clock,
    output var  frt_pkg::frt_pins_t pins
);
    import frt_pkg::*;
    // ****************************************
    // Capture and external count pins
    // ****************************************
    initial pins = '0;
    // Moves one pin, then leaves room for the sync lag and edge spacing
    task automatic drive(input int idx, input logic lvl);
        @(posedge clock);
        case (idx)
            0: pins.captureOne <= lvl;
            1: pins.captureTwo <= lvl;
            default: pins.extCount <= lvl;
        endcase
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// *** bench/free_running_timer_with_capture_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module free_running_timer_with_capture_test;
    import frt_pkg::*;
    // ****************************************
    // Bench signals and instances
    // ****************************************
    logic         clock;
    logic         srst;
    logic         haltMode;
    logic         cpuMask;
    frt_bus_req_t busReq;
    logic [7:0]   readdata;
    logic [7:0]   d0;
    logic [7:0]   d1;
    logic         waitrequest;
    frt_pins_t    pins;
    frt_irq_t     irq;
    int           badCount;
    int           checksDone;

    frt_timer i_frt_timer (
        .clock       (clock),
        .srst        (srst),
        .clockEnable (1'b1),
        .busReq      (busReq),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .pins        (pins),
        .cpuMask     (cpuMask),
        .haltMode    (haltMode),
        .irq         (irq)
    );
    frt_pin_model i_frt_pin_model (
        .clock (clock),
        .pins  (pins)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                          output logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        busReq <= '{read: !wr, write: wr, address: a, writedata: wd};
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        d = readdata;
        busReq <= '0;
        if (n >= 20) begin
            badCount++;
            give_verdict();
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
        access(1'b0, a, 8'h00, d0);
        chk(name, d0, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] wd);
        access(1'b1, a, wd, d1);
    endtask
    task automatic ext(input logic lvl);
        i_frt_pin_model.drive(2, lvl);
    endtask
    task automatic irqchk(input string name, input logic seen, input logic exp);
        chk(name, {7'h00, seen}, {7'h00, exp});
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        srst = 1'b1;
        haltMode = 1'b1;
        cpuMask = 1'b1;
        busReq = '0;
        badCount = 0;
        checksDone = 0;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        rdc(ADDR_CTRL_ONE, 8'h00, "ctrl one");
        rdc(ADDR_CTRL_TWO, 8'h00, "ctrl two");
        rdc(ADDR_FLAGS, 8'h00, "flags");
        rdc(ADDR_COUNT_HIGH, 8'hff, "count high");
        rdc(ADDR_COUNT_LOW, 8'hfc, "count low");
        wr(ADDR_COUNT_HIGH, 8'h12);
        rdc(ADDR_SHADOW_HIGH, 8'hff, "shadow high");
        rdc(ADDR_SHADOW_LOW, 8'hfc, "shadow low");
        rdc(4'hb, 8'h00, "unmapped");
        // Live low byte advance over 64 cycles, last pass halted
        for (int i = 0; i < 4; i++) begin
            haltMode <= (i == 3);
            wr(ADDR_CTRL_TWO, (i == 3) ? 8'h00 : 8'(i << 2));
            access(1'b0, ADDR_COUNT_LOW, 8'h00, d0);
            repeat (61) @(posedge clock);
            access(1'b0, ADDR_COUNT_LOW, 8'h00, d1);
            chk("tick rate", d1 - d0, (i == 3) ? 8'h00 : 8'(64 >> (i + 1)));
        end
        haltMode <= 1'b0;
        wr(ADDR_CTRL_TWO, 8'h0d);
        access(1'b0, ADDR_FLAGS, 8'h00, d1);
        wr(ADDR_COUNT_LOW, 8'h55);
        rdc(ADDR_FLAGS, 8'h00, "flags cleared by write");
        ext(1'b1);
        rdc(ADDR_COUNT_LOW, 8'hfd, "ext rise");
        ext(1'b0);
        rdc(ADDR_COUNT_LOW, 8'hfd, "ext fall");
        ext(1'b1);
        rdc(ADDR_COUNT_HIGH, 8'hff, "seq high");
        ext(1'b0);
        ext(1'b1);
        rdc(ADDR_COUNT_HIGH, 8'hff, "seq high again");
        rdc(ADDR_COUNT_LOW, 8'hfe, "latched low");
        rdc(ADDR_COUNT_LOW, 8'hff, "live low");
        ext(1'b0);
        ext(1'b1);
        rdc(ADDR_COUNT_LOW, 8'h00, "low unarmed");
        rdc(ADDR_FLAGS, 8'h20, "overflow set");
        rdc(ADDR_SHADOW_HIGH, 8'h00, "shadow high");
        rdc(ADDR_SHADOW_LOW, 8'h00, "shadow low");
        rdc(ADDR_FLAGS, 8'h20, "overflow kept");
        wr(ADDR_CTRL_ONE, 8'h20);
        repeat (3) @(posedge clock);
        irqchk("ovf irq masked", irq.overflowIrq, 1'b0);
        cpuMask <= 1'b0;
        repeat (3) @(posedge clock);
        irqchk("ovf irq", irq.overflowIrq, 1'b1);
        rdc(ADDR_COUNT_LOW, 8'h00, "clearing low");
        rdc(ADDR_FLAGS, 8'h00, "overflow cleared");
        irqchk("ovf irq cleared", irq.overflowIrq, 1'b0);
        wr(ADDR_CTRL_ONE, 8'h82);
        wr(ADDR_CTRL_TWO, 8'h0f);
        i_frt_pin_model.drive(0, 1'b1);
        rdc(ADDR_FLAGS, 8'h80, "cap1 flag");
        irqchk("cap irq", irq.captureIrq, 1'b1);
        rdc(ADDR_CAP1_HIGH, 8'h00, "cap1 high");
        rdc(ADDR_CAP1_LOW, 8'h00, "cap1 low");
        rdc(ADDR_FLAGS, 8'h00, "cap1 cleared");
        i_frt_pin_model.drive(0, 1'b0);
        rdc(ADDR_FLAGS, 8'h00, "cap1 wrong edge");
        ext(1'b0);
        ext(1'b1);
        access(1'b0, ADDR_CAP2_HIGH, 8'h00, d1);
        i_frt_pin_model.drive(1, 1'b1);
        rdc(ADDR_FLAGS, 8'h00, "cap2 blocked");
        access(1'b0, ADDR_CAP2_LOW, 8'h00, d1);
        i_frt_pin_model.drive(1, 1'b0);
        ext(1'b0);
        ext(1'b1);
        i_frt_pin_model.drive(1, 1'b1);
        rdc(ADDR_FLAGS, 8'h40, "cap2 flag");
        rdc(ADDR_CAP2_HIGH, 8'h00, "cap2 high");
        rdc(ADDR_CAP2_LOW, 8'h02, "cap2 low");
        wr(ADDR_CTRL_TWO, 8'h1f);
        i_frt_pin_model.drive(0, 1'b1);
        rdc(ADDR_FLAGS, 8'h00, "cap1 in pulse mode");
        i_frt_pin_model.drive(1, 1'b0);
        i_frt_pin_model.drive(1, 1'b1);
        rdc(ADDR_FLAGS, 8'h40, "cap2 in pulse mode");
        give_verdict();
    end
endmodule
`default_nettype wire
